// *** timer16_map.vh ***
// Register offsets, field positions and codes for the 16-bit timer
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH
`define TCTL_ADDR 8'hfb
`define TCTL_RESET 8'h00
`define CNTH_ADDR 8'hf4
`define CNTL_ADDR 8'hf5
`define REFH_ADDR 8'hf6
`define REFL_ADDR 8'hf7
`define PEND_ADDR 8'hf8
`define MASK_ADDR 8'hf9
`define PCFG_ADDR 8'hfa
`define CS_HI 7
`define CS_LO 5
`define MD_HI 4
`define MD_LO 3
`define CLR_BIT 2
`define MIE_BIT 1
`define OIE_BIT 0
`define PEND_OVF_BIT 4
`define PEND_MC_BIT 5
`define MASK_MC_BIT 3
`define PCFG_HI 3
`define PCFG_LO 2
`define PCFG_CAP 2'h0
`define CS_D1024 3'h0
`define CS_D256 3'h1
`define CS_D64 3'h2
`define CS_D8 3'h3
`define CS_D1 3'h4
`define CS_EXTF 3'h5
`define CS_EXTR 3'h6
`define CS_STOP 3'h7
`define MD_INTV 2'h0
`define MD_CAPR 2'h1
`define MD_CAPF 2'h2
`define MD_PWM 2'h3
`define PRE_W 10
`define CNT_MAX 16'hffff
`define CNT_ZERO 16'h0000
`define REF_RESET 16'hffff
`define REF_HI_RESET 8'hff
`define PRE_T1024 9
`define PRE_T256 7
`define PRE_T64 5
`define PRE_T8 2
`endif

// *** edge_sync.v ***
// Two-stage synchroniser with rise and fall pulses
`timescale 1ns/1ns
module edge_sync (
   input wire clk,
   input wire nrst,
   input wire din,
   output reg rise,
   output reg fall
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   always @(posedge clk) begin
      if (!nrst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         rise <= s2_q & ~s3_q;
         fall <= ~s2_q & s3_q;
      end
   end
endmodule

// *** prescaler.v ***
// Free-running divider giving one-cycle ticks at /1024, /256, /64, /8, /1
`timescale 1ns/1ns
`include "timer16_map.vh"
module prescaler (
   input wire clk,
   input wire nrst,
   input wire [2:0] sel,
   output reg tick
);
   reg [`PRE_W-1:0] div_q;
   reg hit;
   always @* begin
      case (sel)
         `CS_D1024: hit = &div_q[`PRE_T1024:0];
         `CS_D256: hit = &div_q[`PRE_T256:0];
         `CS_D64: hit = &div_q[`PRE_T64:0];
         `CS_D8: hit = &div_q[`PRE_T8:0];
         `CS_D1: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   always @(posedge clk) begin
      if (!nrst) begin
         div_q <= {`PRE_W{1'b0}};
         tick <= 1'b0;
      end else begin
         div_q <= div_q + 1'b1;
         tick <= hit;
      end
   end
endmodule

// *** timer16_top.v ***
// 16-bit timer with interval, capture and PWM modes behind byte registers
// Contract
// - Control bits 7:5 codes 000-100 select system clock /1024,/256,/64,/8,/1.
// - Code 101 counts external clock falling edges, 110 rising edges.
// - Code 111 stops the counter, which holds its value.
// - Bits 4:3 select interval, capture rising, capture falling, PWM.
// - Writing 1 to bit 2 clears counter; bit self-clears; 0 does nothing.
// - Reset makes control register zero: interval, /1024, interrupts off.
// - Bit 1 enables the match/capture interrupt request.
// - Bit 0 enables the overflow interrupt request.
// - Both interrupts share one level, with separate vectors.
// - Overflow pending bit 4 cleared by service or software writing 0.
// - With mask bit 3 set, service clears match/capture pending.
// - With mask bit 3 clear, pending bit 5 stays until software writes 0.
// - Interval mode: match raises request, resets counter, keeps counting.
// - Interval mode: output pin inverts on every match.
// - PWM mode: match leaves counter alone; it wraps FFFF to 0000.
// - PWM output low while reference <= counter, high otherwise.
// - Capture mode: selected capture edge loads counter into data register.
// - Capture mode requests overflow on wrap, match/capture on each capture.
// - Capture pin used only when port config bits 3:2 are 00.
// - 16-bit counter, comparator and reference register, byte accessed.
`timescale 1ns/1ns
`include "timer16_map.vh"
module timer16_top (
   // Clock and reset
   input wire I_SYS_CLK,
   input wire I_NRST,
   // Register port
   input wire [7:0] I_ADDR,
   input wire I_WR,
   input wire I_RD,
   input wire [7:0] I_WDATA,
   output reg [7:0] O_RDATA,
   // Interrupt service acknowledges
   input wire I_OVF_ACK,
   input wire I_MC_ACK,
   // Pins
   input wire I_EXT_COUNT_CLOCK,
   input wire I_CAPTURE_IN,
   output reg O_MATCH_TOGGLE_OUT,
   output reg O_PULSE_MOD_OUT,
   // Interrupt requests
   output reg O_SHARED_IRQ_LEVEL,
   output reg O_OVERFLOW_IRQ,
   output reg O_MATCH_CAPTURE_IRQ
);
   reg [7:0] ctl_q;
   reg [15:0] cnt_q;
   reg [15:0] ref_q;
   reg [7:0] ref_hi_hold_q;
   reg ovf_pend_q;
   reg mc_pend_q;
   reg [7:0] mask_q;
   reg [7:0] pcfg_q;
   reg clr_req_q;
   wire pre_tick;
   wire ext_rise;
   wire ext_fall;
   wire cap_rise;
   wire cap_fall;
   wire [2:0] csel;
   wire [1:0] mode;
   reg cnt_tick;
   reg cap_evt;
   wire match;
   wire ovf_evt;
   wire wr_ctl;
   wire cap_pin;

   function wr_hit;
      input [7:0] a;
      input [7:0] b;
      input w;
      begin
         wr_hit = w && (a == b);
      end
   endfunction

   assign csel = ctl_q[`CS_HI:`CS_LO];
   assign mode = ctl_q[`MD_HI:`MD_LO];
   assign wr_ctl = wr_hit(I_ADDR, `TCTL_ADDR, I_WR);
   // Pin gated off unless the port routes it to the timer
   assign cap_pin = (pcfg_q[`PCFG_HI:`PCFG_LO] == `PCFG_CAP) ? I_CAPTURE_IN : 1'b0;

   prescaler u_pre (
      .clk(I_SYS_CLK),
      .nrst(I_NRST),
      .sel(csel),
      .tick(pre_tick)
   );

   edge_sync u_ext (
      .clk(I_SYS_CLK),
      .nrst(I_NRST),
      .din(I_EXT_COUNT_CLOCK),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   edge_sync u_cap (
      .clk(I_SYS_CLK),
      .nrst(I_NRST),
      .din(cap_pin),
      .rise(cap_rise),
      .fall(cap_fall)
   );

   always @* begin
      case (csel)
         `CS_EXTF: cnt_tick = ext_fall;
         `CS_EXTR: cnt_tick = ext_rise;
         `CS_STOP: cnt_tick = 1'b0;
         default: cnt_tick = pre_tick;
      endcase
   end

   always @* begin
      case (mode)
         `MD_CAPR: cap_evt = cap_rise;
         `MD_CAPF: cap_evt = cap_fall;
         default: cap_evt = 1'b0;
      endcase
   end

   // Comparator only counts a match on a count tick, so a held value fires once
   assign match = cnt_tick && (cnt_q == ref_q);
   assign ovf_evt = cnt_tick && (cnt_q == `CNT_MAX) && (mode != `MD_INTV);

   // Control register; the clear bit drops back once the counter is cleared
   always @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         ctl_q <= `TCTL_RESET;
         clr_req_q <= 1'b0;
      end else begin
         if (wr_ctl) begin
            ctl_q <= I_WDATA;
            clr_req_q <= I_WDATA[`CLR_BIT];
         end else if (clr_req_q) begin
            ctl_q[`CLR_BIT] <= 1'b0;
            clr_req_q <= 1'b0;
         end
      end
   end

   // Counter
   always @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         cnt_q <= `CNT_ZERO;
      end else if (clr_req_q) begin
         cnt_q <= `CNT_ZERO;
      end else if (wr_hit(I_ADDR, `CNTL_ADDR, I_WR)) begin
         cnt_q <= {cnt_q[15:8], I_WDATA};
      end else if (wr_hit(I_ADDR, `CNTH_ADDR, I_WR)) begin
         cnt_q <= {I_WDATA, cnt_q[7:0]};
      end else if (cnt_tick) begin
         if (mode == `MD_INTV && match) begin
            cnt_q <= `CNT_ZERO;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // Reference/capture register; high byte staged so a 16-bit update is atomic
   always @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         ref_q <= `REF_RESET;
         ref_hi_hold_q <= `REF_HI_RESET;
      end else if (cap_evt) begin
         ref_q <= cnt_q;
      end else if (wr_hit(I_ADDR, `REFH_ADDR, I_WR)) begin
         ref_hi_hold_q <= I_WDATA;
      end else if (wr_hit(I_ADDR, `REFL_ADDR, I_WR)) begin
         ref_q <= {ref_hi_hold_q, I_WDATA};
      end
   end

   // Port config and mask
   always @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         mask_q <= 8'h00;
         pcfg_q <= 8'h00;
      end else begin
         if (wr_hit(I_ADDR, `MASK_ADDR, I_WR)) begin
            mask_q <= I_WDATA;
         end
         if (wr_hit(I_ADDR, `PCFG_ADDR, I_WR)) begin
            pcfg_q <= I_WDATA;
         end
      end
   end

   // Pending flags; a new event wins over a clear in the same cycle
   always @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         ovf_pend_q <= 1'b0;
         mc_pend_q <= 1'b0;
      end else begin
         if (ovf_evt && ctl_q[`OIE_BIT]) begin
            ovf_pend_q <= 1'b1;
         end else if (I_OVF_ACK) begin
            ovf_pend_q <= 1'b0;
         end else if (wr_hit(I_ADDR, `PEND_ADDR, I_WR) && !I_WDATA[`PEND_OVF_BIT]) begin
            ovf_pend_q <= 1'b0;
         end
         // PWM matches request too; the counter just keeps running
         if ((((mode == `MD_INTV || mode == `MD_PWM) && match) || cap_evt) && ctl_q[`MIE_BIT]) begin
            mc_pend_q <= 1'b1;
         end else if (I_MC_ACK && mask_q[`MASK_MC_BIT]) begin
            mc_pend_q <= 1'b0;
         end else if (wr_hit(I_ADDR, `PEND_ADDR, I_WR) && !I_WDATA[`PEND_MC_BIT]) begin
            mc_pend_q <= 1'b0;
         end
      end
   end

   // Outputs
   always @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         O_MATCH_TOGGLE_OUT <= 1'b0;
         O_PULSE_MOD_OUT <= 1'b0;
         O_OVERFLOW_IRQ <= 1'b0;
         O_MATCH_CAPTURE_IRQ <= 1'b0;
         O_SHARED_IRQ_LEVEL <= 1'b0;
      end else begin
         if (mode == `MD_INTV && match) begin
            O_MATCH_TOGGLE_OUT <= ~O_MATCH_TOGGLE_OUT;
         end
         O_PULSE_MOD_OUT <= (mode == `MD_PWM) && (ref_q > cnt_q);
         O_OVERFLOW_IRQ <= ovf_pend_q;
         O_MATCH_CAPTURE_IRQ <= mc_pend_q;
         O_SHARED_IRQ_LEVEL <= ovf_pend_q | mc_pend_q;
      end
   end

   // Read port
   always @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         O_RDATA <= 8'h00;
      end else if (I_RD) begin
         case (I_ADDR)
            `TCTL_ADDR: O_RDATA <= ctl_q;
            `CNTH_ADDR: O_RDATA <= cnt_q[15:8];
            `CNTL_ADDR: O_RDATA <= cnt_q[7:0];
            `REFH_ADDR: O_RDATA <= ref_q[15:8];
            `REFL_ADDR: O_RDATA <= ref_q[7:0];
            `PEND_ADDR: begin
               O_RDATA <= 8'h00;
               O_RDATA[`PEND_OVF_BIT] <= ovf_pend_q;
               O_RDATA[`PEND_MC_BIT] <= mc_pend_q;
            end
            `MASK_ADDR: O_RDATA <= mask_q;
            `PCFG_ADDR: O_RDATA <= pcfg_q;
            default: O_RDATA <= 8'h00;
         endcase
      end
   end
endmodule

// *** timer16_top_properties.sv ***
// Port-level assertions for the 16-bit timer
`timescale 1ns/1ns
module timer16_top_chk (
   // Clock, reset, register port and service acknowledges
   input wire I_SYS_CLK, I_NRST, I_WR, I_RD, I_OVF_ACK, I_MC_ACK,
   input wire [7:0] I_ADDR, I_WDATA, O_RDATA,
   // Pins and requests
   input wire I_EXT_COUNT_CLOCK, I_CAPTURE_IN, O_MATCH_TOGGLE_OUT, O_PULSE_MOD_OUT,
   input wire O_SHARED_IRQ_LEVEL, O_OVERFLOW_IRQ, O_MATCH_CAPTURE_IRQ
);
   logic [7:0] ctl_q;
   logic mask_q;
   logic pw_q;
   // Shadows of control and mask, same edge as the design takes writes
   always @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         ctl_q <= 8'h00;
         mask_q <= 1'b0;
         pw_q <= 1'b0;
      end else begin
         if (I_WR && I_ADDR == 8'hfb) ctl_q <= I_WDATA;
         if (I_WR && I_ADDR == 8'hf9) mask_q <= I_WDATA[3];
         pw_q <= I_WR && I_ADDR == 8'hf8;
      end
   end
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_NRST);
   // Settle time covers ticks still in flight
   sequence s_stopped; (ctl_q[7:3] == 5'h1c) [*5]; endsequence
   sequence s_no_pwm; (ctl_q[4:3] != 2'h3) [*3]; endsequence
   sequence s_mc_held; O_MATCH_CAPTURE_IRQ && !mask_q && !pw_q && !(I_WR && I_ADDR == 8'hf8); endsequence
   property p_rst; $rose(I_NRST) |-> O_RDATA == 8'h00 && !O_SHARED_IRQ_LEVEL && !O_MATCH_TOGGLE_OUT; endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear");
   property p_clr; I_RD && I_ADDR == 8'hfb |=> !O_RDATA[2]; endproperty
   a_clr: assert property (p_clr) else $error("clear bit reads 1");
   property p_stop; s_stopped |-> $stable(O_MATCH_TOGGLE_OUT); endproperty
   a_stop: assert property (p_stop) else $error("toggle while stopped");
   property p_pwm0; s_no_pwm |-> !O_PULSE_MOD_OUT; endproperty
   a_pwm0: assert property (p_pwm0) else $error("pwm out outside pwm");
   property p_shr; O_SHARED_IRQ_LEVEL == (O_OVERFLOW_IRQ || O_MATCH_CAPTURE_IRQ); endproperty
   a_shr: assert property (p_shr) else $error("shared level wrong");
   property p_oen; $rose(O_OVERFLOW_IRQ) |-> $past(ctl_q[0]) || $past(ctl_q[0], 2) || $past(ctl_q[0], 3); endproperty
   a_oen: assert property (p_oen) else $error("overflow while disabled");
   property p_men; $rose(O_MATCH_CAPTURE_IRQ) |-> $past(ctl_q[1]) || $past(ctl_q[1], 2) || $past(ctl_q[1], 3); endproperty
   a_men: assert property (p_men) else $error("match while disabled");
   property p_oack; I_OVF_ACK && O_OVERFLOW_IRQ |-> ##[1:3] !O_OVERFLOW_IRQ; endproperty
   a_oack: assert property (p_oack) else $error("overflow ack ignored");
   property p_mack; I_MC_ACK && mask_q && O_MATCH_CAPTURE_IRQ |-> ##[1:3] !O_MATCH_CAPTURE_IRQ; endproperty
   a_mack: assert property (p_mack) else $error("match ack ignored");
   property p_mkeep; s_mc_held |=> O_MATCH_CAPTURE_IRQ; endproperty
   a_mkeep: assert property (p_mkeep) else $error("match pending lost");
endmodule
bind timer16_top timer16_top_chk timer16_top_chk_i (.*);

// *** timer16_top_tb.sv ***
// Self-checking bench for the 16-bit timer
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t %h %h", $time, a, b); end end
module timer16_top_tb;
   logic I_SYS_CLK = 0, I_NRST = 0, I_WR = 0, I_RD = 0, I_OVF_ACK = 0, I_MC_ACK = 0;
   logic I_EXT_COUNT_CLOCK = 0, I_CAPTURE_IN = 0;
   logic [7:0] I_ADDR = 0, I_WDATA = 0;
   wire [7:0] O_RDATA;
   wire O_MATCH_TOGGLE_OUT, O_PULSE_MOD_OUT, O_SHARED_IRQ_LEVEL, O_OVERFLOW_IRQ, O_MATCH_CAPTURE_IRQ;
   int err_total = 0, compares = 0, n;
   int dv[5] = '{1024, 256, 64, 8, 1};
   always #4 I_SYS_CLK = ~I_SYS_CLK;
   timer16_top timer16_top_i (.*);
   task end_of_test;
      if (err_total == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task wr(input logic [7:0] a, d);
      @(posedge I_SYS_CLK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WR <= 1;
      @(posedge I_SYS_CLK);
      I_WR <= 0;
   endtask
   task rd(input logic [7:0] a, e);
      @(posedge I_SYS_CLK);
      I_ADDR <= a;
      I_RD <= 1;
      @(posedge I_SYS_CLK);
      I_RD <= 0;
      #1 `CHK(O_RDATA, e)
   endtask
   function logic sg(input int s);
      return s == 0 ? O_MATCH_CAPTURE_IRQ : s == 1 ? O_OVERFLOW_IRQ : O_MATCH_TOGGLE_OUT;
   endfunction
   // Counts cycles until the chosen output changes
   task wt(input int s);
      logic v;
      #1 v = sg(s);
      n = 0;
      do begin
         @(posedge I_SYS_CLK);
         #1 n++;
      end while (sg(s) === v && n < 5000);
      if (n >= 5000) begin
         err_total++;
         end_of_test;
      end
   endtask
   task irq(input int s, input logic e);
      repeat (3) @(posedge I_SYS_CLK);
      #1 `CHK(sg(s), e)
   endtask
   // Leading gap lets in-flight ticks land, since a set beats an ack
   task ack(input int s, input logic e);
      repeat (4) @(posedge I_SYS_CLK);
      if (s == 1) I_OVF_ACK <= 1;
      else I_MC_ACK <= 1;
      @(posedge I_SYS_CLK);
      I_OVF_ACK <= 0;
      I_MC_ACK <= 0;
      irq(s, e);
   endtask
   initial begin
      repeat (20) @(posedge I_SYS_CLK);
      I_NRST <= 1;
      rd(8'hfb, 8'h00);
      rd(8'hf6, 8'hff);
      rd(8'h00, 8'h00);
      wr(8'hf6, 8'h00);
      wr(8'hf7, 8'h03);
      for (int k = 0; k < 5; k++) begin
         wr(8'hfb, {k[2:0], 5'h04});
         wt(2);
         wt(2);
         `CHK(n, 4 * dv[k])
      end
      `CHK(O_MATCH_CAPTURE_IRQ, 1'b0)
      wr(8'hfb, 8'h86);
      rd(8'hfb, 8'h82);
      wt(0);
      `CHK(O_SHARED_IRQ_LEVEL, 1'b1)
      wr(8'hfb, 8'he2);
      ack(0, 1'b1);
      wr(8'hf8, 8'h00);
      irq(0, 1'b0);
      wr(8'hf9, 8'h08);
      wr(8'hfb, 8'h82);
      wt(0);
      wr(8'hfb, 8'he2);
      ack(0, 1'b0);
      wr(8'hfb, 8'hea);
      wr(8'hf4, 8'h12);
      wr(8'hf5, 8'h34);
      I_CAPTURE_IN <= 1;
      wt(0);
      rd(8'hf6, 8'h12);
      rd(8'hf7, 8'h34);
      wr(8'hf8, 8'h00);
      wr(8'hfa, 8'h04);
      wr(8'hf4, 8'h56);
      wr(8'hfb, 8'hf2);
      I_CAPTURE_IN <= 0;
      repeat (8) @(posedge I_SYS_CLK);
      rd(8'hf6, 8'h12);
      wr(8'hfa, 8'h00);
      I_CAPTURE_IN <= 1;
      repeat (8) @(posedge I_SYS_CLK);
      I_CAPTURE_IN <= 0;
      wt(0);
      rd(8'hf6, 8'h56);
      wr(8'hfb, 8'hfd);
      wr(8'hf4, 8'hff);
      wr(8'hf5, 8'hff);
      wr(8'hfb, 8'hd9);
      I_EXT_COUNT_CLOCK <= 1;
      wt(1);
      ack(1, 1'b0);
      rd(8'hf5, 8'h00);
      `CHK(O_PULSE_MOD_OUT, 1'b1)
      wr(8'hfb, 8'hbd);
      I_EXT_COUNT_CLOCK <= 0;
      repeat (8) @(posedge I_SYS_CLK);
      rd(8'hf5, 8'h01);
      wr(8'hfb, 8'hd8);
      wr(8'hf4, 8'hff);
      wr(8'hf5, 8'hff);
      irq(1, 1'b0);
      `CHK(O_PULSE_MOD_OUT, 1'b0)
      @(posedge I_SYS_CLK);
      I_EXT_COUNT_CLOCK <= 1;
      repeat (8) @(posedge I_SYS_CLK);
      irq(1, 1'b0);
      rd(8'hf5, 8'h00);
      end_of_test;
   end
endmodule
